// ===== rtl/clk_select_ctrl.sv
`timescale 1ns/100ps
`include "clk_select_defs.svh"
// Operation
// - Any reset clears the source select field to 00.
// - With reset default config 1, select 00 routes the primary oscillator.
// - With reset default config 0, select 00 routes the internal RC oscillator.
// - Internal RC clocks the device until configuration is loaded, then source chosen.
// - Source switch is glitch-free: two old ticks, then new ticks, clock paused.
// - Select field bits 1:0; 11 internal, 10 primary, 01 secondary.
// - Idle enable bit 7 resets 0; halt enters Idle if set, else Sleep.
// - Start flag bit 3 reads 1 once start-up timer expired and primary runs.
// - Start flag resets 0 with crystal mode plus two-speed start or with internal reset default, else 1.
// - Bits 6 to 4 and bit 2 ignore writes and read zero.
// - Primary runs in primary idle; other power-managed modes stop it.
// - Secondary clocks secondary modes; may run anywhere for timers 1 or 3.
// - Internal Internal_osc_run_mode and idle modes use the 31 kHz internal oscillator.
// - Sleep stops all sources except those enabled for sleep features.
// - Internal RC keeps running while the watchdog is enabled, also in Sleep.
// - Power-up timer always holds the device in reset after power-up.
// - Crystal modes count 1024 primary ticks before the primary clocks; on wake from Sleep the primary clocks at once while the timer recounts.
// - In external clock modes the clock/4 pin is held low in Sleep.
// - Idle bit gates the core clock; select field picks the source.
// - Run and Idle use any source; Sleep uses none.
// - Halt follows the idle bit value at the moment it executes.
// - Secondary select ignored unless secondary oscillator is enabled.
// - Secondary active flag set while secondary clocks; none means internal RC, or primary after a crystal wake from Sleep until recount.
module clk_select_ctrl
   import clk_select_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int POWER_UP_TIMER_W = 12,
   parameter logic [POWER_UP_TIMER_W-1:0] POWER_UP_CYCLES = 12'h400
) (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_cfg_loaded,
   input wire logic i_reset_source_default_cfg,
   input wire logic [1:0] i_oscillator_mode_cfg,
   input wire logic i_two_speed_cfg,
   input wire logic i_watchdog_enable,
   input wire logic i_secondary_osc_enable,
   input wire logic i_sec_osc_ready,
   input wire logic i_sec_timer_sleep,
   input wire logic i_pri_tick,
   input wire logic i_sec_tick,
   input wire logic i_rc_tick,
   input wire logic i_halt,
   input wire logic i_wake,
   output logic [7:0] o_rdata,
   output logic o_pri_osc_en,
   output logic o_sec_osc_en,
   output logic o_rc_osc_en,
   output logic [2:0] o_src_sel,
   output logic o_clk_pause,
   output logic o_core_clk_en,
   output logic o_periph_clk_en,
   output logic o_dev_reset_hold,
   output logic o_osc_out_div4,
   output logic o_secondary_clock_active_flag,
   output logic [2:0] o_power_mode
);

   seq_state_e state;
   seq_state_e next_state;
   clk_src_e cur_src;
   clk_src_e tgt_src;
   power_mode_e pm;
   logic [1:0] clock_source_select;
   logic idle_on_halt_enable;
   logic cfg_default_pri;
   logic [1:0] cfg_mode;
   logic cfg_two_speed;
   logic [POWER_UP_TIMER_W-1:0] power_up_timer_cnt;
   logic [10:0] ost_cnt;
   logic ost_done;
   logic [1:0] sw_cnt;
   logic [1:0] div_cnt;
   logic primary_start_done_flag;
   logic crystal_mode;
   logic ext_clock_mode;
   logic src_ready;
   logic old_tick;
   logic new_tick;
   logic pri_needed;

   // Maps a select value to a source; 00 follows the reset default config
   function automatic clk_src_e src_decode(input logic [1:0] sel, input logic dflt_pri);
      clk_src_e s;
      s = src_internal;
      if (sel == `SCS_PRIMARY) begin
         s = src_primary;
      end else if (sel == `SCS_SECONDARY) begin
         s = src_secondary;
      end else if (sel == `SCS_DEFAULT) begin
         s = dflt_pri ? src_primary : src_internal;
      end
      return s;
   endfunction

   // Tick of a given source, used for both sides of a switch
   function automatic logic src_tick(input clk_src_e s, input logic tp, input logic ts,
                                     input logic tr);
      logic t;
      t = tr;
      if (s == src_primary) begin
         t = tp;
      end else if (s == src_secondary) begin
         t = ts;
      end
      return t;
   endfunction

   assign crystal_mode = (cfg_mode == `MODE_HS) || (cfg_mode == `MODE_HS_MUL);
   assign ext_clock_mode = (cfg_mode == `MODE_EC) || (cfg_mode == `MODE_EC_MUL);
   assign old_tick = src_tick(cur_src, i_pri_tick, i_sec_tick, i_rc_tick);
   assign new_tick = src_tick(tgt_src, i_pri_tick, i_sec_tick, i_rc_tick);

   // Requested source; secondary request without its enable keeps the current one
   always_comb begin
      tgt_src = src_decode(clock_source_select, cfg_default_pri);
      if (tgt_src == src_secondary && !i_secondary_osc_enable) begin
         tgt_src = cur_src;
      end
   end

   // New source readiness; a slow source keeps the old one clocking meanwhile
   always_comb begin
      src_ready = 1'b1;
      if (tgt_src == src_primary) begin
         src_ready = ost_done;
      end else if (tgt_src == src_secondary) begin
         src_ready = i_sec_osc_ready;
      end
   end

   // Control register writes; only bit 7 and bits 1:0 are writable
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         clock_source_select <= `SCS_DEFAULT;
         idle_on_halt_enable <= 1'b0;
      end else if (i_wr && i_addr == `OSC_CTRL_OFFSET) begin
         clock_source_select <= i_wdata[`SCS_MSB:`SCS_LSB];
         idle_on_halt_enable <= i_wdata[`IDLE_EN_BIT];
      end
   end

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= `RDATA_RESET;
      end else if (i_rd && i_addr == `OSC_CTRL_OFFSET) begin
         o_rdata <= `OSC_CTRL_RESET;
         o_rdata[`IDLE_EN_BIT] <= idle_on_halt_enable;
         o_rdata[`START_FLAG_BIT] <= primary_start_done_flag;
         o_rdata[`SCS_MSB:`SCS_LSB] <= clock_source_select;
      end else begin
         o_rdata <= `RDATA_UNMAPPED;
      end
   end

   // Configuration is captured once loaded, never under reset
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_default_pri <= 1'b1;
         cfg_mode <= `MODE_HS;
         cfg_two_speed <= 1'b0;
      end else if (state == st_cfg_load && i_cfg_loaded) begin
         cfg_default_pri <= i_reset_source_default_cfg;
         cfg_mode <= i_oscillator_mode_cfg;
         cfg_two_speed <= i_two_speed_cfg;
      end
   end

   // Power-up timer on the system clock
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         power_up_timer_cnt <= '0;
      end else if (state == st_power_up) begin
         power_up_timer_cnt <= power_up_timer_cnt + 1'b1;
      end
   end

   // Start-up timer counts primary ticks; external clocks need no wait
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ost_cnt <= '0;
         ost_done <= 1'b0;
      end else if (!pri_needed) begin
         ost_cnt <= '0;
         ost_done <= 1'b0;
      end else if (ext_clock_mode) begin
         ost_done <= 1'b1;
      end else if (!ost_done && i_pri_tick) begin
         ost_cnt <= ost_cnt + 1'b1;
         ost_done <= (ost_cnt == `OST_TICKS - 11'h001);
      end
   end

   // Primary wanted while selected, being switched to, or idling on it
   assign pri_needed = (state != st_power_up) && (state != st_cfg_load) &&
      (pm != pm_sleep) && (cur_src == src_primary || tgt_src == src_primary);

   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         st_power_up: begin
            if (power_up_timer_cnt == POWER_UP_CYCLES) begin
               next_state = st_cfg_load;
            end
         end
         st_cfg_load: begin
            if (i_cfg_loaded) begin
               next_state = st_start_wait;
            end
         end
         st_start_wait: begin
            // Without two-speed start the device waits for the crystal in reset
            if (cur_src != src_primary || !crystal_mode || cfg_two_speed || ost_done) begin
               next_state = st_run;
            end
         end
         st_run: begin
            if (tgt_src != cur_src && src_ready && pm != pm_sleep) begin
               next_state = st_sw_old;
            end
         end
         st_sw_old: begin
            if (old_tick && sw_cnt == `SW_OLD_TICKS - 2'h1) begin
               next_state = st_sw_new;
            end
         end
         st_sw_new: begin
            if (new_tick && sw_cnt == `SW_NEW_TICKS - 2'h1) begin
               next_state = st_run;
            end
         end
         default: next_state = st_power_up;
      endcase
   end

   // Sequencer register
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= st_power_up;
      end else begin
         state <= next_state;
      end
   end

   // Pause tick counter, restarted at each phase boundary
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sw_cnt <= '0;
      end else if (next_state != state) begin
         sw_cnt <= '0;
      end else if ((state == st_sw_old && old_tick) || (state == st_sw_new && new_tick)) begin
         sw_cnt <= sw_cnt + 2'h1;
      end
   end

   // Current source; internal RC until configuration is in place
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cur_src <= src_internal;
      end else if (state == st_cfg_load && i_cfg_loaded) begin
         cur_src <= src_decode(clock_source_select, i_reset_source_default_cfg);
      end else if (state == st_start_wait && cur_src == src_primary && crystal_mode &&
                   cfg_two_speed && !ost_done) begin
         cur_src <= src_internal; // Two-speed start runs on RC first
      end else if (state == st_sw_new && next_state == st_run) begin
         cur_src <= tgt_src;
      end
   end

   // Power mode: halt samples the idle bit at that very cycle
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pm <= pm_run;
      end else if (pm == pm_run && i_halt && state == st_run) begin
         pm <= idle_on_halt_enable ? pm_idle : pm_sleep;
      end else if (pm != pm_run && i_wake) begin
         pm <= pm_run;
      end
   end

   // Start flag: primary clocking after timer expiry, cleared in Sleep
   assign primary_start_done_flag = (cur_src == src_primary) && ost_done &&
      (state != st_start_wait) && (pm != pm_sleep);

   // Oscillator enables; Sleep keeps only what sleep features need
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pri_osc_en <= 1'b0;
         o_sec_osc_en <= 1'b0;
         o_rc_osc_en <= 1'b1;
      end else begin
         o_pri_osc_en <= pri_needed;
         o_sec_osc_en <= i_secondary_osc_enable &&
            (pm != pm_sleep || i_sec_timer_sleep);
         o_rc_osc_en <= i_watchdog_enable || state == st_power_up ||
            state == st_cfg_load || (pm != pm_sleep &&
            (cur_src == src_internal || tgt_src == src_internal));
      end
   end

   // Clock gating: idle stops the core only, sleep stops everything
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_src_sel <= src_internal;
         o_clk_pause <= 1'b0;
         o_core_clk_en <= 1'b0;
         o_periph_clk_en <= 1'b0;
         o_dev_reset_hold <= 1'b1;
         o_power_mode <= pm_run;
         o_secondary_clock_active_flag <= 1'b0;
      end else begin
         o_src_sel <= (pm == pm_sleep) ? 3'h0 : cur_src;
         o_clk_pause <= (state == st_sw_old || state == st_sw_new);
         o_core_clk_en <= (state == st_run) && (pm == pm_run);
         o_periph_clk_en <= (state == st_run) && (pm != pm_sleep);
         o_dev_reset_hold <= (state == st_power_up || state == st_cfg_load ||
            state == st_start_wait);
         o_power_mode <= pm;
         o_secondary_clock_active_flag <= (cur_src == src_secondary) &&
            (pm != pm_sleep) && (state == st_run);
      end
   end

   // Clock/4 output exists in external clock modes only and stops low in Sleep
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div_cnt <= '0;
         o_osc_out_div4 <= 1'b0;
      end else if (pm == pm_sleep || !ext_clock_mode) begin
         div_cnt <= '0;
         o_osc_out_div4 <= 1'b0;
      end else if (i_pri_tick) begin
         div_cnt <= div_cnt + 2'h1;
         o_osc_out_div4 <= div_cnt[1];
      end
   end

   // Checks kept next to the logic they guard
   unused_bits_zero_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      i_rd |=> ((o_rdata & `RDATA_UNUSED_MASK) == `RDATA_RESET))
      else $error("unimplemented bits read nonzero");
   halt_mode_select_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (pm == pm_run && i_halt && state == st_run) |=>
      pm == ($past(idle_on_halt_enable) ? pm_idle : pm_sleep))
      else $error("halt entered the wrong power mode");

   sleep_sources_off_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (pm == pm_sleep && !i_watchdog_enable && !i_sec_timer_sleep) ##1
      (pm == pm_sleep) |-> (!o_pri_osc_en && !o_rc_osc_en && !o_sec_osc_en))
      else $error("source running during sleep");

   watchdog_rc_on_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      i_watchdog_enable |=> o_rc_osc_en)
      else $error("internal rc stopped with watchdog enabled");

   switch_pause_held_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (state == st_run && next_state == st_sw_old) |=> ##1 o_clk_pause && !o_core_clk_en)
      else $error("no pause during source switch");
   switch_old_ticks_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (state == st_sw_new && $past(state) == st_sw_old) |->
      ($past(old_tick) && $past(sw_cnt) == `SW_OLD_TICKS - 2'h1))
      else $error("old phase left early");

   secondary_ignored_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (cur_src != src_secondary && !i_secondary_osc_enable) |=> cur_src != src_secondary)
      else $error("secondary entered while disabled");
   start_timer_count_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      ($rose(ost_done) && crystal_mode) |-> $past(ost_cnt) == `OST_TICKS - 11'h001)
      else $error("start-up timer ended at wrong count");

   div4_low_sleep_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (pm == pm_sleep) |=> !o_osc_out_div4)
      else $error("clock/4 output active in sleep");
   default_source_a: assert property (
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (state == st_cfg_load && i_cfg_loaded && !i_reset_source_default_cfg &&
      clock_source_select == `SCS_DEFAULT) |=> cur_src == src_internal)
      else $error("select 00 did not pick internal rc");

endmodule

// ===== rtl/clk_select_defs.svh
`ifndef CLK_SELECT_DEFS_SVH
`define CLK_SELECT_DEFS_SVH

// Register map of the oscillator control register
`define OSC_CTRL_OFFSET 8'h00
`define IDLE_EN_BIT 7
`define START_FLAG_BIT 3
`define SCS_MSB 1
`define SCS_LSB 0
`define OSC_CTRL_RESET 8'h00
`define RDATA_RESET 8'h00
`define RDATA_UNMAPPED 8'h00
`define RDATA_UNUSED_MASK 8'h74

// Source select encodings
`define SCS_DEFAULT 2'h0
`define SCS_SECONDARY 2'h1
`define SCS_PRIMARY 2'h2
`define SCS_INTERNAL 2'h3

// Oscillator mode configuration encodings
`define MODE_HS 2'h0
`define MODE_HS_MUL 2'h1
`define MODE_EC 2'h2
`define MODE_EC_MUL 2'h3

// Timing counts, in ticks of the named source
`define OST_TICKS 11'h400
`define SW_OLD_TICKS 2'h2
`define SW_NEW_TICKS 2'h3

`endif

// ===== rtl/clk_select_pkg.sv
package clk_select_pkg;

   // Sequencer states
   typedef enum logic [5:0] {
      st_power_up = 6'b000001,
      st_cfg_load = 6'b000010,
      st_start_wait = 6'b000100,
      st_run = 6'b001000,
      st_sw_old = 6'b010000,
      st_sw_new = 6'b100000
   } seq_state_e;

   // Clock sources
   typedef enum logic [2:0] {
      src_primary = 3'b001,
      src_secondary = 3'b010,
      src_internal = 3'b100
   } clk_src_e;

   // Power modes of the core
   typedef enum logic [2:0] {
      pm_run = 3'b001,
      pm_idle = 3'b010,
      pm_sleep = 3'b100
   } power_mode_e;

endpackage

// ===== sim/system_clock_select_power_modes_tb_top.sv
`timescale 1ns/100ps
module system_clock_select_power_modes_tb_top
   import clk_select_pkg::*;
;
   typedef struct packed {
      logic [7:0] wdata;
      logic [7:0] rexp;
      logic [2:0] src;
      logic flag;
   } row_s;
   logic i_clk_sys = 1'b0;
   logic i_reset_n = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_cfg_loaded = 1'b0;
   logic i_reset_source_default_cfg = 1'b1;
   logic [1:0] i_oscillator_mode_cfg = 2'h2;
   logic i_two_speed_cfg = 1'b0;
   logic i_watchdog_enable = 1'b1;
   logic i_secondary_osc_enable = 1'b1;
   logic i_sec_osc_ready = 1'b1;
   logic i_sec_timer_sleep = 1'b1;
   logic i_pri_tick = 1'b0;
   logic i_sec_tick = 1'b0;
   logic i_rc_tick = 1'b0;
   logic i_halt = 1'b0;
   logic i_wake = 1'b0;
   logic [7:0] o_rdata;
   logic o_pri_osc_en, o_sec_osc_en, o_rc_osc_en;
   logic [2:0] o_src_sel;
   logic o_clk_pause, o_core_clk_en, o_periph_clk_en, o_dev_reset_hold;
   logic o_osc_out_div4, o_secondary_clock_active_flag;
   logic [2:0] o_power_mode;
   int bad_count = 0;
   int check_count = 0;
   int tcnt = 0;
   int cycles = 0;
   logic [7:0] rd;
   logic [2:0] prev_src;
   int new_ticks;
   int n;
   row_s rows [5] = '{
      '{8'hFF, 8'h83, 3'b100, 1'b0},
      '{8'h01, 8'h01, 3'b010, 1'b1},
      '{8'h72, 8'h0A, 3'b001, 1'b0},
      '{8'h03, 8'h03, 3'b100, 1'b0},
      '{8'h00, 8'h08, 3'b001, 1'b0}};

   clk_select_ctrl #(.ADDR_W(8), .POWER_UP_TIMER_W(12), .POWER_UP_CYCLES(12'h008)) i_dut (
      .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_cfg_loaded(i_cfg_loaded),
      .i_reset_source_default_cfg(i_reset_source_default_cfg),
      .i_oscillator_mode_cfg(i_oscillator_mode_cfg), .i_two_speed_cfg(i_two_speed_cfg),
      .i_watchdog_enable(i_watchdog_enable), .i_secondary_osc_enable(i_secondary_osc_enable),
      .i_sec_osc_ready(i_sec_osc_ready), .i_sec_timer_sleep(i_sec_timer_sleep),
      .i_pri_tick(i_pri_tick), .i_sec_tick(i_sec_tick), .i_rc_tick(i_rc_tick),
      .i_halt(i_halt), .i_wake(i_wake), .o_rdata(o_rdata), .o_pri_osc_en(o_pri_osc_en),
      .o_sec_osc_en(o_sec_osc_en), .o_rc_osc_en(o_rc_osc_en), .o_src_sel(o_src_sel),
      .o_clk_pause(o_clk_pause), .o_core_clk_en(o_core_clk_en),
      .o_periph_clk_en(o_periph_clk_en), .o_dev_reset_hold(o_dev_reset_hold),
      .o_osc_out_div4(o_osc_out_div4),
      .o_secondary_clock_active_flag(o_secondary_clock_active_flag),
      .o_power_mode(o_power_mode));

   // 25 MHz system clock
   always #20 i_clk_sys = ~i_clk_sys;

   // Oscillator ticks at unequal rates so a switch sees distinct old and new cadences
   always @(posedge i_clk_sys) begin
      tcnt <= tcnt + 1;
      i_pri_tick <= (tcnt % 2 == 0);
      i_sec_tick <= (tcnt % 3 == 0);
      i_rc_tick <= (tcnt % 5 == 0);
   end

   // Hang guard; the slow crystal start-up dominates the run time
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   // Read data is only valid in the cycle right after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   task automatic pulse(input bit halt);
      @(posedge i_clk_sys);
      if (halt) i_halt <= 1'b1;
      else i_wake <= 1'b1;
      @(posedge i_clk_sys);
      i_halt <= 1'b0;
      i_wake <= 1'b0;
   endtask

   task automatic wait_mode(input logic [2:0] exp);
      n = 0;
      do begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end while (o_power_mode !== exp && n < 20);
      check("power_mode", {5'h00, o_power_mode}, {5'h00, exp});
   endtask

   // Waits for a source handover, counting new-source ticks seen while paused
   task automatic wait_src(input logic [2:0] exp);
      new_ticks = 0;
      n = 0;
      while (o_src_sel !== exp && n < 3000) begin
         @(posedge i_clk_sys);
         #1;
         n++;
         if (o_clk_pause === 1'b1 && ((exp[0] & i_pri_tick) | (exp[1] & i_sec_tick) |
             (exp[2] & i_rc_tick))) new_ticks++;
         if (o_src_sel === 3'b000) check("src_glitch", 8'h01, 8'h00);
      end
      check("src_sel", {5'h00, o_src_sel}, {5'h00, exp});
   endtask

   task automatic bring_up(input logic dflt, input logic [1:0] mode, input logic two);
      @(posedge i_clk_sys);
      i_reset_n <= 1'b0;
      i_cfg_loaded <= 1'b0;
      i_reset_source_default_cfg <= dflt;
      i_oscillator_mode_cfg <= mode;
      i_two_speed_cfg <= two;
      repeat (20) @(posedge i_clk_sys);
      #1;
      check("rst_rc_en", {7'h00, o_rc_osc_en}, 8'h01);
      check("rst_src", {5'h00, o_src_sel}, 8'h04);
      check("rst_hold", {7'h00, o_dev_reset_hold}, 8'h01);
      check("rst_mode", {5'h00, o_power_mode}, 8'h01);
      @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      repeat (6) @(posedge i_clk_sys);
      #1;
      check("pwr_up_hold", {7'h00, o_dev_reset_hold}, 8'h01);
      repeat (8) @(posedge i_clk_sys);
      #1;
      check("cfg_wait_src", {5'h00, o_src_sel}, 8'h04);
      @(posedge i_clk_sys);
      i_cfg_loaded <= 1'b1;
      n = 0;
      while (o_dev_reset_hold !== 1'b0 && n < 3000) begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      check("hold_release", {7'h00, o_dev_reset_hold}, 8'h00);
   endtask

   initial begin
      // Reset default primary, external clock mode
      bring_up(1'b1, 2'h2, 1'b0);
      check("dflt_src", {5'h00, o_src_sel}, 8'h01);
      reg_read(8'h00, rd);
      check("reset_reg", rd, 8'h08);
      $display("test reset done");
      prev_src = 3'b001;
      foreach (rows[i]) begin
         reg_write(8'h00, rows[i].wdata);
         wait_src(rows[i].src);
         if (rows[i].src !== prev_src) check("new_ticks", new_ticks >= 3, 8'h01);
         prev_src = rows[i].src;
         repeat (2) @(posedge i_clk_sys);
         #1;
         check("pause_end", {7'h00, o_clk_pause}, 8'h00);
         check("sec_flag", {7'h00, o_secondary_clock_active_flag}, rows[i].flag);
         reg_read(8'h00, rd);
         check("readback", rd, rows[i].rexp);
      end
      $display("test select table done");
      reg_write(8'h05, 8'hFF);
      reg_read(8'h05, rd);
      check("unmapped_rd", rd, 8'h00);
      reg_read(8'h00, rd);
      check("after_unmapped", rd, 8'h08);
      $display("test unmapped done");
      @(posedge i_clk_sys);
      i_secondary_osc_enable <= 1'b0;
      reg_write(8'h00, 8'h01);
      repeat (60) @(posedge i_clk_sys);
      #1;
      check("sec_refused", {5'h00, o_src_sel}, 8'h01);
      check("sec_flag_off", {7'h00, o_secondary_clock_active_flag}, 8'h00);
      // Enable only after select leaves 01, else the stale request starts a switch
      reg_write(8'h00, 8'h80);
      i_secondary_osc_enable <= 1'b1;
      wait_src(3'b001);
      $display("test secondary refused done");
      // Idle then sleep, one halt after another with the idle bit changed between
      pulse(1'b1);
      wait_mode(3'b010);
      check("idle_core", {7'h00, o_core_clk_en}, 8'h00);
      check("idle_periph", {7'h00, o_periph_clk_en}, 8'h01);
      check("idle_pri_en", {7'h00, o_pri_osc_en}, 8'h01);
      check("idle_src", {5'h00, o_src_sel}, 8'h01);
      pulse(1'b0);
      wait_mode(3'b001);
      reg_write(8'h00, 8'h00);
      pulse(1'b1);
      wait_mode(3'b100);
      repeat (2) @(posedge i_clk_sys);
      #1;
      check("sleep_src", {5'h00, o_src_sel}, 8'h00);
      check("sleep_clk", {6'h00, o_core_clk_en, o_periph_clk_en}, 8'h00);
      check("sleep_pri_en", {7'h00, o_pri_osc_en}, 8'h00);
      check("sleep_div4", {7'h00, o_osc_out_div4}, 8'h00);
      check("sleep_rc_en", {7'h00, o_rc_osc_en}, 8'h01);
      check("sleep_sec_en", {7'h00, o_sec_osc_en}, 8'h01);
      pulse(1'b0);
      wait_mode(3'b001);
      // Sleep with no sleep feature enabled must stop every source
      @(posedge i_clk_sys);
      i_watchdog_enable <= 1'b0;
      i_sec_timer_sleep <= 1'b0;
      pulse(1'b1);
      wait_mode(3'b100);
      repeat (2) @(posedge i_clk_sys);
      #1;
      check("sleep_all_off", {5'h00, o_pri_osc_en, o_rc_osc_en, o_sec_osc_en}, 8'h00);
      pulse(1'b0);
      wait_mode(3'b001);
      $display("test halt done");
      // Reset in mid-run with internal default and crystal two-speed start
      bring_up(1'b0, 2'h0, 1'b1);
      check("dflt_rc_src", {5'h00, o_src_sel}, 8'h04);
      reg_read(8'h00, rd);
      check("two_speed_reg", rd, 8'h00);
      reg_write(8'h00, 8'h02);
      new_ticks = 0;
      n = 0;
      while (o_src_sel !== 3'b001 && n < 4000) begin
         @(posedge i_clk_sys);
         #1;
         n++;
         if (i_pri_tick === 1'b1) new_ticks++;
      end
      check("start_timer", new_ticks >= 1024, 8'h01);
      reg_read(8'h00, rd);
      check("start_done", rd, 8'h0A);
      $display("test crystal start done");
      end_of_test();
   end
endmodule
